// >>> core/slpr_defs.svh
`ifndef SLPR_DEFS_SVH
`define SLPR_DEFS_SVH

// register offsets on the serial control port
`define SLPR_OFF_CTRL3 13'h0062
`define SLPR_OFF_M 13'h0071
`define SLPR_OFF_RES 13'h0072
`define SLPR_OFF_NP 13'h0073
`define SLPR_OFF_S 13'h0074
`define SLPR_OFF_HDCF 13'h0075
`define SLPR_OFF_SCR1 13'h0076
`define SLPR_OFF_SCR2 13'h0077
`define SLPR_OFF_SUM0 13'h0078
`define SLPR_OFF_SUM1 13'h0079

// field positions
`define SLPR_SUMDIS_BIT 7
`define SLPR_CS_MSB 7
`define SLPR_CS_LSB 6
`define SLPR_READ_BIT 15

// fixed read-only values, minus-one coded where applicable
`define SLPR_N_VAL 5'h0d
`define SLPR_NP_VAL 5'h0f
`define SLPR_S_VAL 5'h00
`define SLPR_CF_VAL 5'h00
`define SLPR_HD_VAL 1'b0
`define SLPR_CS_UNUSED 2'h3

// reset values
`define SLPR_RST_M 1'b0
`define SLPR_RST_CS 2'h0
`define SLPR_RST_BYTE 8'h00

// frame bit counts: 16 instruction bits, then 8 data bits
`define SLPR_LAST_INSTR 5'h0f
`define SLPR_LAST_DATA 5'h17

`endif

// >>> core/slpr_pkg.sv
package slpr_pkg;

	// link parameters owned by neighbouring registers
	typedef struct packed {
		logic [7:0] did; // device id
		logic [3:0] bid; // bank id
		logic [4:0] lid0; // lane id, lane 0
		logic [4:0] lid1; // lane id, lane 1
		logic scr; // scrambler on
		logic l_minus1; // lanes per link minus one
		logic [7:0] f_minus1; // octets per frame minus one
		logic [4:0] k_minus1; // frames per multiframe minus one
	} slpr_link_t;

	// configuration handed to the link framing logic
	typedef struct packed {
		logic m; // converters per link minus one
		logic [1:0] cs; // control bits per sample
		logic [7:0] ctrl3; // link control 3, bit 7 kills checksum
	} slpr_cfg_t;

	// register access decoded from the serial port
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic [12:0] addr; // register address
		logic [7:0] wdata; // write data
	} slpr_req_t;

	typedef enum logic [4:0] {
		st_idle = 5'h01,
		st_instr = 5'h02,
		st_wdata = 5'h04,
		st_rdata = 5'h08,
		st_done = 5'h10
	} slpr_spi_st_t;

	// serial port state, bit order sclk, select, sdio
	typedef struct packed {
		logic [2:0] sy1; // first sync stage
		logic [2:0] sy2; // second sync stage
		logic [2:0] sy3; // third sync stage
		logic [2:0] filt; // agreed pin levels
		slpr_spi_st_t st; // frame phase
		logic [4:0] cnt; // rising edges seen
		logic [15:0] instr; // instruction shifter
		logic [7:0] osr; // read data shifter
		logic loaded; // read byte taken
		logic oe; // sdio driven
		slpr_req_t req; // decoded access
	} slpr_spi_state_t;

	// register bank state
	typedef struct packed {
		logic m;
		logic [1:0] cs;
		logic [7:0] ctrl3;
		logic [7:0] scr1;
		logic [7:0] scr2;
		logic [7:0] sum0;
		logic [7:0] sum1;
	} slpr_bank_t;

endpackage : slpr_pkg

// >>> core/slpr_regs.sv
// Summary of operation
// (RULE_01) bit zero picks one or two converters
// (RULE_02) control bits field: 0, 1, 2; 3 unused
// (RULE_03) resolution field reads fixed 13, read-only
// (RULE_04) total bits per sample reads fixed 15
// (RULE_05) samples per frame reads fixed zero
// (RULE_06) high density bit always reads zero
// (RULE_07) control words per frame reads zero
// (RULE_08) two free scratch bytes, read and write
// (RULE_09) lane 0 sum of parameters, modulo 256
// (RULE_10) lane 1 sum of parameters, modulo 256
// (RULE_11) host keeps port idle during critical sampling
// (RULE_12) checksum-disable bit forces checksums off
// (RULE_13) host powers link down while reconfiguring
// (RULE_14) sums recompute after any parameter change
`timescale 1ns/1ps
`include "slpr_defs.svh"

module slpr_regs (
	input wire logic i_mclk, // system clock, 10 MHz
	input wire logic i_srst, // sync reset, high
	input wire logic i_sclk, // serial clock pin
	input wire logic i_port_select_n, // port select pin, low
	input wire logic i_sdio, // sdio pin level
	output logic o_sdio, // sdio drive value
	output logic o_sdio_oe, // sdio drive enable
	input slpr_pkg::slpr_link_t i_link, // neighbour parameters
	output slpr_pkg::slpr_cfg_t o_cfg, // configuration out
	output logic [7:0] o_lane_sum0, // lane 0 checksum
	output logic [7:0] o_lane_sum1 // lane 1 checksum
);

	slpr_pkg::slpr_bank_t q; // registered bank
	slpr_pkg::slpr_bank_t n; // next bank
	slpr_pkg::slpr_req_t req; // access from the port
	logic [7:0] rdata; // read mux

	// sum of every link parameter of one lane, 8-bit wrap gives modulo 256
	// carries out of bit 7 are simply dropped, so no separate modulo step is needed
	function automatic logic [7:0] lane_sum(input slpr_pkg::slpr_link_t lk,
			input logic [4:0] lid, input slpr_pkg::slpr_bank_t b);
		lane_sum = lk.did + {4'h0, lk.bid} + {3'h0, lid} + {7'h00, lk.scr}
			+ {7'h00, lk.l_minus1} + lk.f_minus1 + {3'h0, lk.k_minus1}
			+ {7'h00, b.m} + {6'h00, b.cs} + {3'h0, `SLPR_N_VAL}
			+ {3'h0, `SLPR_NP_VAL} + {3'h0, `SLPR_S_VAL} + {7'h00, `SLPR_HD_VAL}
			+ {3'h0, `SLPR_CF_VAL} + b.scr1 + b.scr2;
	endfunction : lane_sum

	// serial control port front end
	slpr_spi_port u_port (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_sclk(i_sclk),
		.i_port_select_n(i_port_select_n),
		.i_sdio(i_sdio),
		.i_rdata(rdata),
		.o_sdio(o_sdio),
		.o_sdio_oe(o_sdio_oe),
		.o_req(req)
	);

	// writes and checksum update
	// one register per frame, so at most one written field moves in any clock
	always_comb begin
		n = q;
		if (req.wr) begin
			case (req.addr)
				`SLPR_OFF_CTRL3: begin
					// only the top bit acts here, the rest is passed on untouched
					n.ctrl3 = req.wdata;
				end
				`SLPR_OFF_M: begin
					n.m = req.wdata[0]; // RULE_01
				end
				`SLPR_OFF_RES: begin
					// unused code is refused, resolution bits are fixed
					if (req.wdata[`SLPR_CS_MSB:`SLPR_CS_LSB] != `SLPR_CS_UNUSED) begin
						n.cs = req.wdata[`SLPR_CS_MSB:`SLPR_CS_LSB]; // RULE_02
					end
				end
				`SLPR_OFF_SCR1: begin
					n.scr1 = req.wdata; // RULE_08
				end
				`SLPR_OFF_SCR2: begin
					n.scr2 = req.wdata; // RULE_08
				end
				default: begin
					// read-only or unmapped: write ignored
				end
			endcase
		end
		// recomputed every cycle, so sums lag a change by one clock
		if (q.ctrl3[`SLPR_SUMDIS_BIT]) begin
			n.sum0 = 8'h00; // RULE_12
			n.sum1 = 8'h00; // RULE_12
		end else begin
			n.sum0 = lane_sum(i_link, i_link.lid0, q); // RULE_09 RULE_14
			n.sum1 = lane_sum(i_link, i_link.lid1, q); // RULE_10 RULE_14
		end
	end

	// bank register
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			q <= '0;
			q.m <= `SLPR_RST_M;
			q.cs <= `SLPR_RST_CS;
			q.ctrl3 <= `SLPR_RST_BYTE;
			q.scr1 <= `SLPR_RST_BYTE;
			q.scr2 <= `SLPR_RST_BYTE;
		end else begin
			q <= n;
		end
	end

	// read mux; open and reserved bits read zero, unmapped reads zero
	always_comb begin
		case (req.addr)
			`SLPR_OFF_CTRL3: rdata = q.ctrl3;
			`SLPR_OFF_M: rdata = {7'h00, q.m}; // RULE_01
			`SLPR_OFF_RES: rdata = {q.cs, 1'b0, `SLPR_N_VAL}; // RULE_03
			`SLPR_OFF_NP: rdata = {3'h0, `SLPR_NP_VAL}; // RULE_04
			`SLPR_OFF_S: rdata = {3'h0, `SLPR_S_VAL}; // RULE_05
			`SLPR_OFF_HDCF: rdata = {`SLPR_HD_VAL, 2'h0, `SLPR_CF_VAL}; // RULE_06 RULE_07
			`SLPR_OFF_SCR1: rdata = q.scr1;
			`SLPR_OFF_SCR2: rdata = q.scr2;
			`SLPR_OFF_SUM0: rdata = q.sum0;
			`SLPR_OFF_SUM1: rdata = q.sum1;
			default: rdata = 8'h00;
		endcase
	end

	// straight from flops, so the framing logic never sees a glitch
	assign o_cfg = '{m: q.m, cs: q.cs, ctrl3: q.ctrl3};
	assign o_lane_sum0 = q.sum0;
	assign o_lane_sum1 = q.sum1;

	property p_m_write;
		@(posedge i_mclk) disable iff (i_srst)
		req.wr && req.addr == `SLPR_OFF_M |=> o_cfg.m == $past(req.wdata[0]);
	endproperty
	a_m_write: assert property (p_m_write) // RULE_01
		else $error("converter count not taken from write");

	property p_cs_write;
		@(posedge i_mclk) disable iff (i_srst)
		req.wr && req.addr == `SLPR_OFF_RES |=>
			o_cfg.cs == (($past(req.wdata[7:6]) == `SLPR_CS_UNUSED) ?
			$past(o_cfg.cs) : $past(req.wdata[7:6]));
	endproperty
	a_cs_write: assert property (p_cs_write) // RULE_02
		else $error("control bits field wrong after write");

	property p_res_ro;
		@(posedge i_mclk) disable iff (i_srst)
		req.addr == `SLPR_OFF_RES |-> rdata[5:0] == {1'b0, `SLPR_N_VAL};
	endproperty
	a_res_ro: assert property (p_res_ro) // RULE_03
		else $error("resolution readback wrong");

	property p_np_ro;
		@(posedge i_mclk) disable iff (i_srst)
		req.addr == `SLPR_OFF_NP |-> rdata == 8'h0f;
	endproperty
	a_np_ro: assert property (p_np_ro) // RULE_04
		else $error("bits per sample readback wrong");

	property p_s_ro;
		@(posedge i_mclk) disable iff (i_srst)
		req.addr == `SLPR_OFF_S |-> rdata == 8'h00;
	endproperty
	a_s_ro: assert property (p_s_ro) // RULE_05
		else $error("samples per frame readback wrong");

	property p_hd_ro;
		@(posedge i_mclk) disable iff (i_srst)
		req.addr == `SLPR_OFF_HDCF |-> !rdata[7];
	endproperty
	a_hd_ro: assert property (p_hd_ro) // RULE_06
		else $error("high density bit set");

	property p_cf_ro;
		@(posedge i_mclk) disable iff (i_srst)
		req.addr == `SLPR_OFF_HDCF |-> rdata[4:0] == 5'h00;
	endproperty
	a_cf_ro: assert property (p_cf_ro) // RULE_07
		else $error("control words per frame not zero");

	property p_scratch;
		@(posedge i_mclk) disable iff (i_srst)
		req.wr && req.addr == `SLPR_OFF_SCR1 |=>
			q.scr1 == $past(req.wdata) && $stable(q.scr2) && $stable(q.m);
	endproperty
	a_scratch: assert property (p_scratch) // RULE_08
		else $error("scratch write lost or leaked");

	property p_sum_lanes;
		@(posedge i_mclk) disable iff (i_srst)
		!$past(q.ctrl3[7]) |->
			8'(o_lane_sum0 - o_lane_sum1) == 8'($past(i_link.lid0) - $past(i_link.lid1));
	endproperty
	a_sum_lanes: assert property (p_sum_lanes) // RULE_09 RULE_10
		else $error("lane sums differ by more than lane ids");

	property p_sum_track;
		@(posedge i_mclk) disable iff (i_srst)
		(req.wr && req.addr == `SLPR_OFF_SCR1 && !q.ctrl3[7]) ##1 $stable(i_link) |=>
			8'(o_lane_sum0 - $past(o_lane_sum0)) == 8'($past(q.scr1) - $past(q.scr1, 2));
	endproperty
	a_sum_track: assert property (p_sum_track) // RULE_14
		else $error("lane sum did not follow scratch change");

	// same tracking on lane 1, driven by the second scratch byte
	property p_sum_track2;
		@(posedge i_mclk) disable iff (i_srst)
		(req.wr && req.addr == `SLPR_OFF_SCR2 && !q.ctrl3[7]) ##1 $stable(i_link) |=>
			8'(o_lane_sum1 - $past(o_lane_sum1)) == 8'($past(q.scr2) - $past(q.scr2, 2));
	endproperty
	a_sum_track2: assert property (p_sum_track2) // RULE_14
		else $error("lane 1 sum did not follow scratch change");

	property p_sum_dis;
		@(posedge i_mclk) disable iff (i_srst)
		q.ctrl3[7] |=> o_lane_sum0 == 8'h00 && o_lane_sum1 == 8'h00;
	endproperty
	a_sum_dis: assert property (p_sum_dis) // RULE_12
		else $error("checksum not disabled");

endmodule : slpr_regs

// >>> core/slpr_spi_port.sv
`timescale 1ns/1ps
`include "slpr_defs.svh"

module slpr_spi_port (
	input wire logic i_mclk, // system clock
	input wire logic i_srst, // sync reset, high
	input wire logic i_sclk, // serial clock pin
	input wire logic i_port_select_n, // port select pin, low
	input wire logic i_sdio, // sdio pin level
	input wire logic [7:0] i_rdata, // read mux for o_req.addr
	output logic o_sdio, // sdio drive value
	output logic o_sdio_oe, // sdio drive enable
	output slpr_pkg::slpr_req_t o_req // decoded access
);

	slpr_pkg::slpr_spi_state_t q; // registered state
	slpr_pkg::slpr_spi_state_t n; // next state
	logic rise; // sclk rising
	logic fall; // sclk falling
	logic [15:0] ins; // instruction after this bit

	// pins are async: three stages, a change counts once stages two and three agree.
	// sclk is treated as data, so the port works at any sclk below mclk / 8.
	always_comb begin
		n = q;
		ins = {q.instr[14:0], q.filt[2]};
		n.req.wr = 1'b0;
		n.sy1 = {i_sdio, i_port_select_n, i_sclk};
		n.sy2 = q.sy1;
		n.sy3 = q.sy2;
		for (int i = 0; i < 3; i++) begin
			if (q.sy2[i] == q.sy3[i]) begin
				n.filt[i] = q.sy3[i];
			end
		end
		rise = n.filt[0] & ~q.filt[0];
		fall = ~n.filt[0] & q.filt[0];
		ins = {q.instr[14:0], n.filt[2]};
		if (n.filt[1]) begin
			// deselected: abort any frame, release sdio
			n.st = slpr_pkg::st_idle;
			n.cnt = 5'h00;
			n.oe = 1'b0;
			n.loaded = 1'b0;
		end else begin
			case (q.st)
				slpr_pkg::st_idle: begin
					n.st = slpr_pkg::st_instr;
				end
				slpr_pkg::st_instr: begin
					if (rise) begin
						n.instr = ins;
						n.cnt = q.cnt + 5'h01;
						if (q.cnt == `SLPR_LAST_INSTR) begin
							n.req.addr = ins[12:0];
							n.st = ins[`SLPR_READ_BIT] ? slpr_pkg::st_rdata : slpr_pkg::st_wdata;
						end
					end
				end
				slpr_pkg::st_wdata: begin
					if (rise) begin
						n.req.wdata = {q.req.wdata[6:0], n.filt[2]};
						n.cnt = q.cnt + 5'h01;
						if (q.cnt == `SLPR_LAST_DATA) begin
							n.req.wr = 1'b1;
							n.st = slpr_pkg::st_done;
						end
					end
				end
				slpr_pkg::st_rdata: begin
					// first falling edge after the instruction loads the byte
					if (fall) begin
						if (!q.loaded) begin
							n.osr = i_rdata;
							n.loaded = 1'b1;
							n.oe = 1'b1;
						end else begin
							n.osr = {q.osr[6:0], 1'b0};
						end
					end
				end
				slpr_pkg::st_done: begin
					n.st = slpr_pkg::st_done;
				end
				default: begin
					n.st = slpr_pkg::st_idle;
				end
			endcase
		end
	end

	// state register; select pins reset to idle level
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			q <= '0;
			q.st <= slpr_pkg::st_idle;
			q.sy1 <= 3'h2;
			q.sy2 <= 3'h2;
			q.sy3 <= 3'h2;
			q.filt <= 3'h2;
		end else begin
			q <= n;
		end
	end

	assign o_req = q.req;
	assign o_sdio = q.osr[7];
	assign o_sdio_oe = q.oe;

	property p_oe_read;
		@(posedge i_mclk) disable iff (i_srst)
		q.oe |-> (q.st == slpr_pkg::st_rdata) && !q.filt[1];
	endproperty
	a_oe_read: assert property (p_oe_read)
		else $error("sdio driven outside a read frame");

endmodule : slpr_spi_port

// >>> verif/slpr_regs_tb.sv
`timescale 1ns/1ps

module slpr_regs_tb;
	logic i_mclk = 1'b0; // bench clock
	logic i_srst = 1'b1; // sync reset
	logic i_sclk = 1'b0; // serial clock, idles low
	logic i_port_select_n = 1'b1; // select, idle high
	logic host_sdio = 1'b0; // host drive value
	logic i_sdio; // resolved wire
	logic o_sdio; // device drive value
	logic o_sdio_oe; // device drive enable
	slpr_pkg::slpr_link_t i_link = '0; // neighbour params
	slpr_pkg::slpr_cfg_t o_cfg; // config out
	logic [7:0] o_lane_sum0; // lane 0 sum
	logic [7:0] o_lane_sum1; // lane 1 sum
	int bad_count = 0; // mismatches
	int comparisons = 0; // checks made
	logic m_e = 1'b0; // expected converters bit
	logic [1:0] cs_e = 2'h0; // expected control bits
	logic [7:0] c3_e = 8'h00; // expected link control 3
	logic [7:0] s1_e = 8'h00; // expected scratch one
	logic [7:0] s2_e = 8'h00; // expected scratch two
	logic [7:0] rd; // last read byte
	logic [63:0] rnd; // random source

	// free-running clock, 100 ns
	always #50 i_mclk = ~i_mclk;

	// wire level: device wins while it drives
	assign i_sdio = o_sdio_oe ? o_sdio : host_sdio;

	slpr_regs i_slpr_regs (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_sclk(i_sclk),
		.i_port_select_n(i_port_select_n),
		.i_sdio(i_sdio),
		.o_sdio(o_sdio),
		.o_sdio_oe(o_sdio_oe),
		.i_link(i_link),
		.o_cfg(o_cfg),
		.o_lane_sum0(o_lane_sum0),
		.o_lane_sum1(o_lane_sum1)
	);

	// expected checksum for one lane
	function automatic logic [7:0] exp_sum(input logic [4:0] lid);
		logic [7:0] s;
		s = i_link.did + 8'(i_link.bid) + 8'(lid) + 8'(i_link.scr) + 8'(i_link.l_minus1)
			+ i_link.f_minus1 + 8'(i_link.k_minus1) + 8'(m_e) + 8'(cs_e) + 8'h0d + 8'h0f
			+ s1_e + s2_e;
		return c3_e[7] ? 8'h00 : s;
	endfunction : exp_sum

	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// verdict and end of run
	task automatic stop_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// one frame; nb below 24 aborts it, sclk held low 6 mclk and high 5 mclk per bit
	task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] wd,
			input int nb, output logic [7:0] q);
		logic [23:0] f;
		f = {r, 2'b00, a, wd};
		q = 8'h00;
		i_port_select_n <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			i_sclk <= 1'b0;
			// released wire while device talks: keep it moving, never stale
			host_sdio <= (r && i > 15) ? ~host_sdio : f[23 - i];
			repeat (5) @(posedge i_mclk);
			@(negedge i_mclk);
			q = {q[6:0], i_sdio};
			@(posedge i_mclk);
			i_sclk <= 1'b1;
			repeat (5) @(posedge i_mclk);
		end
		i_sclk <= 1'b0;
		repeat (5) @(posedge i_mclk);
		i_port_select_n <= 1'b1;
		repeat (6) @(posedge i_mclk);
	endtask : xfer

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		xfer(1'b0, a, d, 24, rd);
	endtask : wr

	task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
		xfer(1'b1, a, 8'h00, 24, rd);
		chk(rd, exp);
	endtask : rdc

	// sums on the pins and through the port
	task automatic chk_sums;
		chk(o_lane_sum0, exp_sum(i_link.lid0));
		chk(o_lane_sum1, exp_sum(i_link.lid1));
		rdc(13'h0078, exp_sum(i_link.lid0));
		rdc(13'h0079, exp_sum(i_link.lid1));
	endtask : chk_sums

	// main sequence
	initial begin
		void'($urandom(5519));
		repeat (4) @(posedge i_mclk);
		i_srst <= 1'b0;
		repeat (3) @(posedge i_mclk);
		chk({7'h0, o_sdio_oe}, 8'h00);
		chk({5'h0, o_cfg.m, o_cfg.cs}, 8'h00);
		// read-only places refuse writes
		for (int k = 3; k < 6; k++) begin
			wr(13'h0070 + 13'(k), 8'hff);
		end
		wr(13'h0078, 8'h55);
		rdc(13'h0073, 8'h0f);
		rdc(13'h0074, 8'h00);
		rdc(13'h0075, 8'h00);
		rdc(13'h0010, 8'h00);
		chk({7'h0, o_sdio_oe}, 8'h00);
		// converters bit, both settings; 0x0060 written 1 meanwhile, an unmapped address the bank ignores
		wr(13'h0060, 8'h01);
		for (int k = 0; k < 2; k++) begin
			m_e = k[0];
			wr(13'h0071, {7'h0, m_e});
			chk({7'h0, o_cfg.m}, {7'h0, m_e});
			rdc(13'h0071, {7'h0, m_e});
		end
		// every control-bits code; the unused one is refused
		for (int k = 0; k < 4; k++) begin
			wr(13'h0072, {k[1:0], 6'h3f});
			if (k < 3) begin
				cs_e = k[1:0];
			end
			chk({6'h0, o_cfg.cs}, {6'h0, cs_e});
			rdc(13'h0072, {cs_e, 1'b0, 5'h0d});
		end
		wr(13'h0060, 8'h00);
		chk_sums();
		// random link params and scratch values
		for (int k = 0; k < 5; k++) begin
			rnd = {$urandom(), $urandom()};
			i_link <= rnd[36:0];
			s1_e = rnd[48:41];
			s2_e = rnd[56:49];
			wr(13'h0076, s1_e);
			wr(13'h0077, s2_e);
			rdc(13'h0076, s1_e);
			rdc(13'h0077, s2_e);
			chk_sums();
			// neighbour change only: sums follow within a few clocks
			rnd = {$urandom(), $urandom()};
			i_link <= rnd[36:0];
			repeat (3) @(posedge i_mclk);
			chk(o_lane_sum0, exp_sum(i_link.lid0));
			chk(o_lane_sum1, exp_sum(i_link.lid1));
		end
		// checksum kill bit
		c3_e = 8'h80;
		wr(13'h0062, c3_e);
		rdc(13'h0062, c3_e);
		chk(o_cfg.ctrl3, c3_e);
		chk_sums();
		c3_e = 8'h00;
		wr(13'h0062, c3_e);
		chk(o_cfg.ctrl3, c3_e);
		chk_sums();
		// aborted write and unmapped write leave scratch alone
		xfer(1'b0, 13'h0076, ~s1_e, 20, rd);
		wr(13'h0010, 8'haa);
		rdc(13'h0076, s1_e);
		rdc(13'h0010, 8'h00);
		stop_test();
	end

	// hang guard, well above the longest sequence
	initial begin
		#5000000;
		bad_count++;
		stop_test();
	end
endmodule : slpr_regs_tb
